// *** rtl/fsps_pkg.sv ***
package fsps_pkg;
	// Register map, byte addresses on the Wishbone slave
	localparam logic [3:0] FSPS_ADDR_CTRL = 4'h0;
	localparam logic [3:0] FSPS_ADDR_PTR = 4'h4;
	localparam logic [3:0] FSPS_ADDR_DATA = 4'h8;
	localparam logic [3:0] FSPS_ADDR_STAT = 4'hc;
	// Control/status bit positions
	localparam int FSPS_BIT_EN = 0;
	localparam int FSPS_BIT_ERS = 1;
	localparam int FSPS_BIT_WRT = 2;
	localparam int FSPS_BIT_LBS = 3;
	localparam int FSPS_BIT_RRE = 4;
	localparam int FSPS_BIT_SIG = 5;
	localparam int FSPS_BIT_BSY = 6;
	localparam int FSPS_BIT_IE = 7;
	// Accepted low-five-bit command codes
	localparam logic [4:0] FSPS_CMD_LOAD = 5'h01;
	localparam logic [4:0] FSPS_CMD_ERASE = 5'h03;
	localparam logic [4:0] FSPS_CMD_WRITE = 5'h05;
	localparam logic [4:0] FSPS_CMD_LOCK = 5'h09;
	localparam logic [4:0] FSPS_CMD_REEN = 5'h11;
	localparam logic [7:0] FSPS_CTRL_RST = 8'h00;
	// Arming window in clock cycles
	localparam logic [2:0] FSPS_ARM_CYC = 3'h4;
	// Flash operation durations
	localparam int FSPS_OP_TIME_US = 4000;
	localparam int FSPS_CLK_MHZ = 25;
	localparam int FSPS_OP_CYC = FSPS_OP_TIME_US * FSPS_CLK_MHZ;
	typedef enum logic [1:0] {FSPS_IDLE, FSPS_ARMED, FSPS_BUSY} fsps_state_type;
endpackage : fsps_pkg

// *** rtl/fsps_sequencer.sv ***
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - erase page when armed store arrives
// - erase select clears on finish or timeout
// - halt core erasing stalling area
// - concurrent area operations keep core running
// - halt core writing stalling area
// - enable arms store for four cycles
// - lone enable loads word into buffer
// - enable clears on completion or timeout
// - enable stays high while flash busy
// - only five command patterns accepted
// - target address latched at start
// - erase addressed by page index only
// - load addressed by word-in-page field
// - buffer cleared after write, reenable, reset
// - data EEPROM write discards loaded words
// - write addressed by page index
// - ready interrupt level while enable zero
// - buffer words loadable in any order
// - busy flag set by concurrent ops, cleared by reenable or load
// - interrupt needs local and global enable
module fsps_sequencer #(
	parameter int WORD_BITS = 6,
	parameter int PAGE_BITS = 9,
	parameter int STALL_FIRST_PAGE = 448,
	parameter int OP_CYCLES = fsps_pkg::FSPS_OP_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic store_instr_i,
	input wire logic global_irq_en_i,
	input wire logic eeprom_write_i,
	output logic core_halt_o,
	output logic irq_o,
	output logic concurrent_area_busy_o,
	output logic flash_erase_o,
	output logic flash_write_o,
	output logic [PAGE_BITS-1:0] flash_page_o,
	output logic [15:0] flash_wdata_o,
	output logic [WORD_BITS-1:0] flash_word_o
);
	import fsps_pkg::*;

	localparam int WORDS = 1 << WORD_BITS;
	localparam int ZBITS = PAGE_BITS + WORD_BITS + 1;
	// The last arming cycle; a store may still land on it
	localparam logic [2:0] ARM_LAST = FSPS_ARM_CYC - 3'h1;
	// Clock enable low freezes every register, the arming window included

	// The pointer is 16 bits wide, and a one-cycle operation would end
	// before the core halt could take effect
	if (ZBITS > 16 || STALL_FIRST_PAGE >= (1 << PAGE_BITS) || OP_CYCLES < 2 || WORD_BITS < 1)
	begin : g_bad_params
		$error("fsps_sequencer: unsupported parameters");
	end

	fsps_state_type state_q;
	logic [7:0] ctrl_q;
	logic [15:0] ptr_q;
	logic [15:0] data_q;
	logic [2:0] arm_cnt_q;
	logic [31:0] op_cnt_q;
	logic [PAGE_BITS-1:0] op_page_q;
	logic op_write_q;
	logic [15:0] buf_q [WORDS];
	// Only words marked here hold loaded data
	logic [WORDS-1:0] buf_valid_q;
	logic [1:0] eep_sync_q;
	logic eep_prev_q;
	logic bus_req;
	logic ctrl_wr;
	logic [4:0] cmd;
	logic cmd_ok;
	logic fire;
	logic timeout;
	logic op_done;
	logic eep_rise;
	logic fire_page;
	logic fire_load;
	logic fire_reen;
	logic [PAGE_BITS-1:0] ptr_page;
	logic [WORD_BITS-1:0] ptr_word;

	// Lock-set is accepted, but it only clears the command bits
	function automatic logic cmd_valid(input logic [4:0] c);
		return c == FSPS_CMD_LOAD || c == FSPS_CMD_ERASE || c == FSPS_CMD_WRITE ||
			c == FSPS_CMD_LOCK || c == FSPS_CMD_REEN;
	endfunction : cmd_valid

	function automatic logic page_stalls(input logic [PAGE_BITS-1:0] p);
		return int'(p) >= STALL_FIRST_PAGE;
	endfunction : page_stalls

	// Erase and write hold the flash array busy;
	// load, reenable and lock-set finish at once
	function automatic logic is_page_op(input logic [4:0] c);
		return c[FSPS_BIT_ERS] || c[FSPS_BIT_WRT];
	endfunction : is_page_op

	// The ack term keeps a request held through its ack from being taken twice
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign ctrl_wr = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == FSPS_ADDR_CTRL;
	// Command code lives in the low five bits
	assign cmd = wb_dat_i[4:0];
	assign cmd_ok = cmd_valid(cmd) && state_q != FSPS_BUSY;
	assign fire = state_q == FSPS_ARMED && store_instr_i;
	// four-cycle window
	// Counted in enabled clock edges after the accepted write
	assign timeout = state_q == FSPS_ARMED && !store_instr_i && arm_cnt_q == ARM_LAST;
	// Marks the last busy cycle
	assign op_done = state_q == FSPS_BUSY && op_cnt_q == 32'h0;
	// Only the rising edge counts; a long EEPROM write discards once
	assign eep_rise = eep_sync_q[1] && !eep_prev_q;

	// Pointer bit 0 selects a byte and is ignored by every command
	assign ptr_word = ptr_q[WORD_BITS:1];
	assign ptr_page = ptr_q[WORD_BITS+1 +: PAGE_BITS];
	assign fire_page = fire && is_page_op(ctrl_q[4:0]);
	assign fire_load = fire && ctrl_q[4:0] == FSPS_CMD_LOAD;
	assign fire_reen = fire && ctrl_q[4:0] == FSPS_CMD_REEN;

	// Pin is from another block's timing; synchronise it
	// Logic reads only the second stage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			eep_sync_q <= 2'h0;
			eep_prev_q <= 1'b0;
		end
		else if (ce_i)
		begin
			eep_sync_q <= {eep_sync_q[0], eeprom_write_i};
			eep_prev_q <= eep_sync_q[1];
		end
	end

	// Bus slave: one-cycle ack, zero for unmapped reads
	// Ack is registered, so the answer comes one cycle after the request is taken
	// Unmapped writes match no decode and are lost
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else if (ce_i)
		begin
			wb_ack_o <= bus_req;
			case (wb_adr_i)
				FSPS_ADDR_CTRL: wb_dat_o <= {24'h0, ctrl_q};
				FSPS_ADDR_PTR: wb_dat_o <= {16'h0, ptr_q};
				FSPS_ADDR_DATA: wb_dat_o <= {16'h0, data_q};
				// Status: bit 0 flash busy, bit 1 core held
				FSPS_ADDR_STAT: wb_dat_o <= {30'h0, core_halt_o, state_q == FSPS_BUSY};
				default: wb_dat_o <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ptr_q <= 16'h0;
			data_q <= 16'h0;
		end
		else if (ce_i && bus_req && wb_we_i)
		begin
			// Byte lanes let software set each pointer half on its own
			if (wb_adr_i == FSPS_ADDR_PTR)
			begin
				if (wb_sel_i[0])
					ptr_q[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					ptr_q[15:8] <= wb_dat_i[15:8];
			end
			if (wb_adr_i == FSPS_ADDR_DATA)
			begin
				if (wb_sel_i[0])
					data_q[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					data_q[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// Command sequencer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= FSPS_IDLE;
			arm_cnt_q <= 3'h0;
			op_cnt_q <= 32'h0;
			op_page_q <= '0;
			op_write_q <= 1'b0;
		end
		else if (ce_i)
		begin
			case (state_q)
				FSPS_IDLE:
				begin
					// Commands are refused while busy, through cmd_ok
					if (ctrl_wr && cmd_ok)
					begin
						state_q <= FSPS_ARMED;
						arm_cnt_q <= 3'h0;
					end
				end
				FSPS_ARMED:
				begin
					if (ctrl_wr && cmd_ok && !store_instr_i)
						arm_cnt_q <= 3'h0;
					else if (fire)
					begin
						// latch page
						// Software may reuse the pointer while the flash is busy
						op_page_q <= ptr_page;
						op_write_q <= ctrl_q[FSPS_BIT_WRT];
						op_cnt_q <= 32'(OP_CYCLES - 1);
						if (is_page_op(ctrl_q[4:0]))
							state_q <= FSPS_BUSY;
						else
							state_q <= FSPS_IDLE;
					end
					else if (timeout)
						state_q <= FSPS_IDLE;
					else
						arm_cnt_q <= arm_cnt_q + 3'h1;
				end
				FSPS_BUSY:
				begin
					// Count runs down to zero over OP_CYCLES-1 edges
					if (op_done)
						state_q <= FSPS_IDLE;
					else
						op_cnt_q <= op_cnt_q - 32'h1;
				end
				// Unused encoding falls back to idle
				default: state_q <= FSPS_IDLE;
			endcase
		end
	end

	// Control/status register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_q <= FSPS_CTRL_RST;
		else if (ce_i)
		begin
			if (ctrl_wr)
				ctrl_q[FSPS_BIT_IE] <= wb_dat_i[FSPS_BIT_IE];
			// Bit 7 follows every control write, even a refused command
			// A store firing this cycle owns the command bits; a racing write is dropped
			if (ctrl_wr && cmd_ok && !fire)
				ctrl_q[4:0] <= cmd;
			else if ((fire && !is_page_op(ctrl_q[4:0])) || timeout)
				ctrl_q[4:0] <= 5'h0;
			else if (op_done)
				ctrl_q[4:0] <= 5'h0;
			if (fire_page && !page_stalls(ptr_page))
				ctrl_q[FSPS_BIT_BSY] <= 1'b1;
			// Read access returns only by a reenable or a new load
			else if (fire_reen || fire_load)
				ctrl_q[FSPS_BIT_BSY] <= 1'b0;
		end
	end

	// Temporary page buffer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			buf_valid_q <= '0;
		else if (ce_i)
		begin
			if ((op_done && op_write_q) || fire_reen || eep_rise)
				// A load in the same cycle as a discard survives it
				buf_valid_q <= fire_load ? WORDS'(1) << ptr_word : '0;
			else if (fire_load)
				buf_valid_q[ptr_word] <= 1'b1;
		end
	end

	// No reset here: only words marked valid are ever read out
	always_ff @(posedge clk_i)
	begin
		if (ce_i && fire_load)
			buf_q[ptr_word] <= data_q;
	end

	// Flash drive: erase writes ones, write streams buffer words
	// Words leave counting down; a run shorter than a page streams only its low words
	// Unloaded words go out as ones so they stay blank
	// Page and word outputs are registered copies of the latched operation
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			flash_erase_o <= 1'b0;
			flash_write_o <= 1'b0;
			flash_page_o <= '0;
			flash_wdata_o <= 16'h0;
			flash_word_o <= '0;
		end
		else if (ce_i)
		begin
			flash_page_o <= op_page_q;
			flash_erase_o <= state_q == FSPS_BUSY && !op_write_q;
			flash_write_o <= state_q == FSPS_BUSY && op_write_q && op_cnt_q < 32'(WORDS);
			flash_word_o <= op_cnt_q[WORD_BITS-1:0];
			flash_wdata_o <= buf_valid_q[op_cnt_q[WORD_BITS-1:0]] ? buf_q[op_cnt_q[WORD_BITS-1:0]] : 16'hffff;
		end
	end

	// Outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			core_halt_o <= 1'b0;
			irq_o <= 1'b0;
			concurrent_area_busy_o <= 1'b0;
		end
		else if (ce_i)
		begin
			// concurrent area keeps running
			// Halt starts on the firing edge so the core never fetches mid-operation
			core_halt_o <= (fire_page && page_stalls(ptr_page)) ||
				(state_q == FSPS_BUSY && !op_done && page_stalls(op_page_q));
			// both enables needed
			// Level: stays up until software arms a new command or either enable drops
			// Both enables are sampled here, so a change shows one cycle later
			irq_o <= ctrl_q[FSPS_BIT_IE] && global_irq_en_i && !ctrl_q[FSPS_BIT_EN];
			// Mirror of the status bit for the fetch path
			concurrent_area_busy_o <= ctrl_q[FSPS_BIT_BSY];
		end
	end
endmodule : fsps_sequencer

// *** dv/fsps_checker.sv ***
`timescale 1ns/1ps
module fsps_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic store_instr_i,
	input wire logic global_irq_en_i,
	input wire logic core_halt_o,
	input wire logic irq_o,
	input wire logic flash_erase_o,
	input wire logic flash_write_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// An operation may only start one or two edges after a store
	sequence s_fired;
		$past(store_instr_i) || $past(store_instr_i, 2);
	endsequence
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ers_src;
		$rose(flash_erase_o) |-> s_fired;
	endproperty
	a_ers_src: assert property (p_ers_src) else $error("erase without store");
	property p_wrt_src;
		$rose(flash_write_o) |-> s_fired;
	endproperty
	a_wrt_src: assert property (p_wrt_src) else $error("write without store");
	property p_op_excl;
		!(flash_erase_o && flash_write_o);
	endproperty
	a_op_excl: assert property (p_op_excl) else $error("two operations");
	property p_halt;
		core_halt_o |-> (flash_erase_o || flash_write_o || $past(flash_erase_o || flash_write_o)) or ##1 flash_erase_o;
	endproperty
	a_halt: assert property (p_halt) else $error("halt outside operation");
	property p_irq;
		irq_o |-> $past(global_irq_en_i);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without global enable");
	property p_ers_len;
		$rose(flash_erase_o) |-> flash_erase_o[*8] ##[1:1000] !flash_erase_o;
	endproperty
	a_ers_len: assert property (p_ers_len) else $error("erase length wrong");
endmodule : fsps_checker
bind fsps_sequencer fsps_checker i_fsps_checker (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .store_instr_i(store_instr_i), .global_irq_en_i(global_irq_en_i),
	.core_halt_o(core_halt_o), .irq_o(irq_o), .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o));

// *** dv/fsps_core_model.sv ***
`timescale 1ns/1ps
module fsps_core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic [2:0] dly_i,
	output logic store_o
);
	logic act_q;
	logic [2:0] cnt_q;
	always_ff @(posedge clk_i)
	begin
		store_o <= 1'b0;
		if (rst_i)
			act_q <= 1'b0;
		else if (go_i && !act_q)
		begin
			act_q <= 1'b1;
			cnt_q <= dly_i;
		end
		else if (act_q && cnt_q == 3'h0)
		begin
			store_o <= 1'b1;
			act_q <= 1'b0;
		end
		else if (act_q)
			cnt_q <= cnt_q - 3'h1;
	end
endmodule : fsps_core_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import fsps_pkg::*;
	`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("Error %0t: got %h expected %h", $time, a, b); end end
	logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, gie = 0, go = 0, eep = 0, st;
	logic [5:0] wrd;
	logic [15:0] wdat;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rd, q;
	logic [2:0] dly = 3'h0;
	logic ack, halt, irq, busy, ers, wrt;
	logic [8:0] pg;
	int error_cnt = 0, n_checks = 0;
	initial forever #20 clk_i = ~clk_i;
	fsps_sequencer #(.OP_CYCLES(20)) i_fsps_sequencer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(adr),
		.wb_dat_i(wd), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack),
		.store_instr_i(st), .global_irq_en_i(gie), .eeprom_write_i(eep), .core_halt_o(halt), .irq_o(irq),
		.concurrent_area_busy_o(busy), .flash_erase_o(ers), .flash_write_o(wrt), .flash_page_o(pg),
		.flash_wdata_o(wdat), .flash_word_o(wrd));
	fsps_core_model i_fsps_core_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .dly_i(dly), .store_o(st));
	task automatic conclude;
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		adr <= a;
		we <= w;
		wd <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			error_cnt++;
			conclude();
		end
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	// Store lands on the last cycle of the arming window after the control write
	task automatic fire;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : fire
	task automatic wait_idle;
		int n;
		for (n = 0; n < 40; n++)
		begin
			wb(FSPS_ADDR_CTRL, 1'b0, 32'h0);
			if (q[0] === 1'b0)
				break;
		end
		if (n == 40)
		begin
			error_cnt++;
			conclude();
		end
	endtask : wait_idle
	task automatic s_refuse;
		wb(FSPS_ADDR_CTRL, 1'b1, 32'h07);
		wb(FSPS_ADDR_CTRL, 1'b0, 32'h0);
		`CHK(q[4:0], 5'h00)
		wb(FSPS_ADDR_CTRL, 1'b1, 32'h03);
		repeat (6) @(posedge clk_i);
		wb(FSPS_ADDR_CTRL, 1'b0, 32'h0);
		`CHK(q[4:0], 5'h00)
	endtask : s_refuse
	task automatic s_erase_stall;
		wb(FSPS_ADDR_PTR, 1'b1, 32'he000);
		wb(FSPS_ADDR_CTRL, 1'b1, 32'h83);
		wb(FSPS_ADDR_CTRL, 1'b1, 32'h83);
		fire();
		`CHK(ers, 1'b1)
		`CHK(halt, 1'b1)
		`CHK(pg, 9'd448)
		gie <= 1'b1;
		wb(FSPS_ADDR_PTR, 1'b1, 32'h0);
		`CHK(pg, 9'd448)
		wb(FSPS_ADDR_CTRL, 1'b0, 32'h0);
		`CHK(q[0], 1'b1)
		`CHK(irq, 1'b0)
		wait_idle();
		`CHK(halt, 1'b0)
		repeat (2) @(posedge clk_i);
		`CHK(irq, 1'b1)
		gie <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK(irq, 1'b0)
	endtask : s_erase_stall
	// Page 5 sits in the concurrent area; other pointer bits stay zero
	task automatic page_op(input logic [7:0] c);
		wb(FSPS_ADDR_PTR, 1'b1, 32'h0280);
		wb(FSPS_ADDR_CTRL, 1'b1, {24'h0, c});
		fire();
	endtask : page_op
	// Word 2 with pointer bit 0 set, which must be ignored
	task automatic load_w2(input logic [15:0] d);
		wb(FSPS_ADDR_PTR, 1'b1, 32'h0005);
		wb(FSPS_ADDR_DATA, 1'b1, {16'h0, d});
		wb(FSPS_ADDR_CTRL, 1'b1, 32'h01);
		fire();
	endtask : load_w2
	// Follows the write stream until buffer word 2 goes out
	task automatic see_w2(output logic [15:0] w);
		int n;
		w = 16'h0;
		for (n = 0; n < 40; n++)
		begin
			if (wrt === 1'b1 && wrd === 6'h02)
				break;
			@(posedge clk_i);
		end
		if (n == 40)
		begin
			error_cnt++;
			conclude();
		end
		w = wdat;
		wait_idle();
	endtask : see_w2
	task automatic s_write_conc;
		logic [15:0] w;
		page_op(8'h03);
		`CHK(halt, 1'b0)
		`CHK(busy, 1'b1)
		wait_idle();
		// word 2 loaded once per buffer fill
		load_w2(16'h1234);
		`CHK(busy, 1'b0)
		wb(FSPS_ADDR_CTRL, 1'b0, 32'h0);
		`CHK(q[0], 1'b0)
		page_op(8'h05);
		`CHK(wrt, 1'b1)
		`CHK(pg, 9'd5)
		`CHK(halt, 1'b0)
		`CHK(busy, 1'b1)
		see_w2(w);
		`CHK(w, 16'h1234)
		page_op(8'h03);
		wait_idle();
		page_op(8'h05);
		see_w2(w);
		`CHK(w, 16'hffff)
		page_op(8'h03);
		wait_idle();
		load_w2(16'h5678);
		eep <= 1'b1;
		repeat (4) @(posedge clk_i);
		eep <= 1'b0;
		page_op(8'h05);
		see_w2(w);
		`CHK(w, 16'hffff)
	endtask : s_write_conc
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		s_refuse();
		s_erase_stall();
		s_write_conc();
		conclude();
	end
endmodule : tb_top
